// *** include/crosspoint_pkg.sv ***
// constants shared by the crosspoint serial control design
package crosspoint_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // matrix geometry
  localparam int NUM_OUT = 16;
  localparam int SEL_BITS = 4;
  localparam int FIELD_BITS = 6;
  localparam int MATRIX_BITS = 96;
  localparam int SINGLE_BITS = 16;
  localparam int ID_BITS = 4;

  ////////////////////////////////////////////////////////////////////////////
  // 6-bit whole-matrix field layout
  localparam int FLD_SEL_LO = 0;
  localparam int FLD_GAIN = 4;
  localparam int FLD_EN = 5;

  ////////////////////////////////////////////////////////////////////////////
  // 16-bit single-output word layout
  localparam int SW_SEL_LO = 0;
  localparam int SW_GAIN = 4;
  localparam int SW_EN = 5;
  localparam int SW_OUT_LO = 6;
  localparam int SW_ID_LO = 10;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on the wishbone port
  localparam int ADR_BITS = 8;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_SHIFT_LO = 8'h08;
  localparam logic [7:0] ADR_SHIFT_MID = 8'h0C;
  localparam logic [7:0] ADR_SHIFT_HI = 8'h10;
  localparam logic [7:0] ADR_SINGLE = 8'h14;
  localparam logic [1:0] ADR_LATCH_PAGE = 2'h1;
  localparam int CTRL_FORCE_OFF = 0;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  // synchroniser reset: sclk, din, chain en (idle high), update (idle high), mode, strap
  localparam logic [8:0] PIN_RST = 9'h060;

endpackage

// *** rtl/crosspoint_serial_control.sv ***
// serial control logic of a 16x16 crosspoint switch with wishbone status port
`timescale 1ns/10ps
`default_nettype none

module crosspoint_serial_control
  import crosspoint_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // wishbone slave
  input wire logic [ADR_BITS-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial pins
  input wire logic shiftClock,
  input wire logic serialIn,
  input wire logic chainEnN,
  input wire logic updateN,
  input wire logic modeSelect,
  input wire logic [ID_BITS-1:0] chipStrapAddress,
  output logic serialOut,
  output logic addrMatchN,
  // matrix control latches
  output logic [NUM_OUT-1:0] outEnable,
  output logic [NUM_OUT-1:0] outGain,
  output logic [NUM_OUT*SEL_BITS-1:0] outSelect
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // every pin, straps included, passes two flops: the straps are static
  // in use, but a jumper moved under power must not upset the compare
  logic [8:0] pinSync;
  logic sclkSync;
  logic dinSync;
  logic chainEnNSync;
  logic updateNSync;
  logic modeSync;
  logic [ID_BITS-1:0] strapSync;

  pin_sync #(.W(9), .RST_VAL(PIN_RST)) u_pin_sync (
    .clk(ref_clk),
    .nrst(nrst),
    .din({shiftClock, serialIn, chainEnN, updateN, modeSelect, chipStrapAddress}),
    .dout(pinSync)
  );

  // unpack the synchronised pins
  assign sclkSync = pinSync[8];
  assign dinSync = pinSync[7];
  assign chainEnNSync = pinSync[6];
  assign updateNSync = pinSync[5];
  assign modeSync = pinSync[4];
  assign strapSync = pinSync[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // edge detection and pin outputs
  logic sclkPrev_reg;
  logic sclkPrev_next;
  logic updPrev_reg;
  logic updPrev_next;
  logic serialOut_next;
  logic addrMatchN_next;
  logic active;
  logic sclkFall;
  logic updFall;
  logic shiftEn;
  logic idMatch;

  // link timing seen from ref_clk, counted from the pin edge:
  //   edges 1 and 2 move the pin through the synchroniser
  //   edge 3 sees sync low and history high, the shift takes place
  //   serial out settles on that same edge, the match flag on edge 3 of an update fall
  // so each link phase must last at least three ref_clk periods;
  // a faster link clock loses falling edges without any warning.
  // mode 0 pass-through is registered too, three ref_clk behind the pin.
  // the chain enable gates the detector result, not the history, so
  // the history keeps running while idle and no stale edge is taken
  // when the chain is enabled again.

  // link clock is slow against ref_clk, so edges are found by sampling
  assign active = ~chainEnNSync;
  assign sclkFall = sclkPrev_reg & ~sclkSync;
  assign updFall = updPrev_reg & ~updateNSync;
  assign shiftEn = active & updateNSync & sclkFall;

  logic [MATRIX_BITS-1:0] matrixShift_reg;
  logic [MATRIX_BITS-1:0] matrixShift_next;
  logic [SINGLE_BITS-1:0] singleShift_reg;
  logic [SINGLE_BITS-1:0] singleShift_next;

  // chip id field of the single-output word against the straps
  assign idMatch = (singleShift_reg[SW_ID_LO +: ID_BITS] == strapSync);

  // pass-through costs one ref_clk of latency since outputs are registered
  always_comb begin
    sclkPrev_next = sclkSync;
    updPrev_next = updateNSync;
    serialOut_next = serialOut;
    if (!modeSync) begin
      serialOut_next = dinSync;
    end else begin
      // top bit after any shift on this edge, so the next device takes it on the next fall
      serialOut_next = matrixShift_next[MATRIX_BITS-1];
    end
    addrMatchN_next = ~(active & ~modeSync & ~updateNSync & idMatch);
  end

  // edge history and pin outputs; the history resets to the idle pin
  // levels, so the first edge seen after reset is a real one
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sclkPrev_reg <= 1'b0;
      updPrev_reg <= 1'b1;
      serialOut <= 1'b0;
      addrMatchN <= 1'b1;
    end else begin
      sclkPrev_reg <= sclkPrev_next;
      updPrev_reg <= updPrev_next;
      serialOut <= serialOut_next;
      addrMatchN <= addrMatchN_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift registers and gain/select latches, kept across reset
  logic [NUM_OUT-1:0] outGain_next;
  logic [NUM_OUT*SEL_BITS-1:0] outSelect_next;
  logic [NUM_OUT-1:0] outEnable_next;
  logic [NUM_OUT-1:0] fieldEn;
  logic [NUM_OUT-1:0] fieldGain;
  logic [NUM_OUT*SEL_BITS-1:0] fieldSel;
  logic [NUM_OUT-1:0] singleHit;
  logic matrixLoad;
  logic singleLoad;
  logic forceOff;

  // loads happen once per update falling edge; holding update low does
  // not reload, and no shifting takes place while it is low
  assign matrixLoad = active & modeSync & updFall;
  assign singleLoad = active & ~modeSync & updFall & idMatch;

  // whole-matrix word, six bits per output, output 15 in the top field:
  //   [95:90] output 15 ... [5:0] output 0
  //   field bit 5 enable, bit 4 gain, bits 3..0 input select
  // single-output word:
  //   [3:0] input select, [4] gain, [5] enable,
  //   [9:6] output number, [13:10] chip id, [15:14] unused
  // both words go most significant bit first.
  // gain and select survive reset on purpose, so that one update
  // after reset can bring the old routing back with the enables.

  // per-output fields of the 96-bit word and single-word address decode
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_field
      assign fieldEn[gi] = matrixShift_reg[gi*FIELD_BITS + FLD_EN];
      assign fieldGain[gi] = matrixShift_reg[gi*FIELD_BITS + FLD_GAIN];
      assign fieldSel[gi*SEL_BITS +: SEL_BITS] = matrixShift_reg[gi*FIELD_BITS + FLD_SEL_LO +: SEL_BITS];
      assign singleHit[gi] = singleLoad & (singleShift_reg[SW_OUT_LO +: SEL_BITS] == SEL_BITS'(gi));
    end
  endgenerate

  // msb first: new bit enters at bit 0, oldest leaves at the top
  always_comb begin
    matrixShift_next = matrixShift_reg;
    singleShift_next = singleShift_reg;
    outGain_next = outGain;
    outSelect_next = outSelect;
    outEnable_next = outEnable;
    if (shiftEn && modeSync) begin
      matrixShift_next = {matrixShift_reg[MATRIX_BITS-2:0], dinSync};
    end
    if (shiftEn && !modeSync) begin
      singleShift_next = {singleShift_reg[SINGLE_BITS-2:0], dinSync};
    end
    if (matrixLoad) begin
      outGain_next = fieldGain;
      outSelect_next = fieldSel;
      outEnable_next = fieldEn;
    end
    // a single-output hit never meets a matrix load: the modes differ
    for (int i = 0; i < NUM_OUT; i++) begin
      if (singleHit[i]) begin
        outGain_next[i] = singleShift_reg[SW_GAIN];
        outSelect_next[i*SEL_BITS +: SEL_BITS] = singleShift_reg[SW_SEL_LO +: SEL_BITS];
        outEnable_next[i] = singleShift_reg[SW_EN];
      end
    end
    // force-off wins over any load in the same cycle
    if (forceOff) begin
      outEnable_next = '0;
    end
  end

  // no reset here: contents survive a reset pulse
  always_ff @(posedge ref_clk) begin
    matrixShift_reg <= matrixShift_next;
    singleShift_reg <= singleShift_next;
    outGain <= outGain_next;
    outSelect <= outSelect_next;
  end

  // enables alone are cleared by reset
  // force-off acts here as well, one edge after the control write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      outEnable <= '0;
    end else begin
      outEnable <= outEnable_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic ack_next;
  logic [31:0] datOut_next;
  logic [31:0] readMux;
  logic [SEL_BITS-1:0] latchIdx;
  logic [31:0] statusWord;
  logic busReq;
  logic ctrlWrite;

  assign forceOff = ctrl_reg[CTRL_FORCE_OFF];
  assign latchIdx = wb_adr_i[5:2];
  // a request is taken once; ack low marks its first cycle
  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // control writes need the low byte lane, the only one in use
  assign ctrlWrite = busReq & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADR_CTRL);

  // register map, byte addresses:
  //   0x00 control, bit 0 holds every output disabled while set
  //   0x04 status: bit 0 match, bit 1 update low, bit 2 chain
  //        active, bit 3 mode, bits 7..4 strap address
  //   0x08, 0x0c, 0x10 whole-matrix shift register, low word first
  //   0x14 single-output shift register in bits 15..0
  //   0x40 + 4*i latch of output i: enable 5, gain 4, select 3..0
  // writes anywhere but 0x00 are dropped; holes read as zero.
  // status bits 7..1 are the synchronised pins, so they trail the pins by
  // two ref_clk periods, and bit 0 is the registered match flag; software
  // polling them never sees metastable values.

  // status word from the synchronised pins and the match flag
  always_comb begin
    statusWord = DATA_ZERO;
    statusWord[0] = ~addrMatchN;
    statusWord[1] = ~updateNSync;
    statusWord[2] = active;
    statusWord[3] = modeSync;
    statusWord[7:4] = strapSync;
  end

  // read decode; unmapped addresses answer zero
  always_comb begin
    readMux = DATA_ZERO;
    case (wb_adr_i)
      ADR_CTRL: begin
        readMux = ctrl_reg;
      end
      ADR_STATUS: begin
        readMux = statusWord;
      end
      ADR_SHIFT_LO: begin
        readMux = matrixShift_reg[31:0];
      end
      ADR_SHIFT_MID: begin
        readMux = matrixShift_reg[63:32];
      end
      ADR_SHIFT_HI: begin
        readMux = matrixShift_reg[95:64];
      end
      ADR_SINGLE: begin
        readMux = {16'h0000, singleShift_reg};
      end
      default: begin
        if (wb_adr_i[7:6] == ADR_LATCH_PAGE) begin
          readMux = {26'h000_0000, outEnable[latchIdx], outGain[latchIdx],
                     outSelect[latchIdx*SEL_BITS +: SEL_BITS]};
        end
      end
    endcase
  end

  // one wait state: ack one cycle after the request, dropped the next;
  // the master holds its request, so data taken here still stands at ack
  always_comb begin
    ack_next = busReq;
    ctrl_next = ctrl_reg;
    datOut_next = wb_dat_o;
    if (busReq) begin
      datOut_next = readMux;
    end
    if (ctrlWrite) begin
      ctrl_next = {31'h0000_0000, wb_dat_i[CTRL_FORCE_OFF]};
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= CTRL_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= DATA_ZERO;
    end else begin
      ctrl_reg <= ctrl_next;
      wb_ack_o <= ack_next;
      wb_dat_o <= datOut_next;
    end
  end

endmodule // crosspoint_serial_control
`default_nettype wire

// *** rtl/pin_sync.sv ***
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pin side and synchronised side
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_next;

  // first stage only feeds the second stage
  always_comb begin
    meta_next = din;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      dout <= sync_next;
    end
  end

endmodule // pin_sync
`default_nettype wire

// *** sim/crosspoint_serial_control_sva.sv ***
// assertion checker watching the crosspoint serial control ports
`timescale 1ns/10ps
`default_nettype none
module crosspoint_sva
  import crosspoint_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // serial pins
  input wire logic serialIn,
  input wire logic chainEnN,
  input wire logic updateN,
  input wire logic modeSelect,
  input wire logic serialOut,
  input wire logic addrMatchN,
  // matrix latches
  input wire logic [NUM_OUT-1:0] outEnable,
  input wire logic [NUM_OUT-1:0] outGain,
  input wire logic [NUM_OUT*SEL_BITS-1:0] outSelect
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  // bus answer comes one cycle after a request and lasts one cycle
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  // reset must blank the outputs even while it is active
  a_reset_off: assert property (disable iff (1'b0) !nrst |-> outEnable == '0)
    else $error("outputs enabled in reset");
  a_match_mode: assert property (!addrMatchN |-> !modeSelect && !chainEnN)
    else $error("match outside single mode");
  a_match_update: assert property ($fell(addrMatchN) |-> !updateN)
    else $error("match without update");
  // gain and select move only under an enabled update strobe; enables rise only while update is low
  a_latch_cause: assert property ($changed({outGain, outSelect}) |-> !updateN && !chainEnN)
    else $error("latch changed without update");
  a_enable_rise: assert property ((outEnable & ~$past(outEnable)) != '0 |-> !updateN)
    else $error("enable rose without update");
  a_sout_follow: assert property ((!modeSelect && $stable(serialIn))[*6] |-> serialOut == serialIn)
    else $error("serial out not following");
endmodule // crosspoint_sva

bind crosspoint_serial_control crosspoint_sva chk (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .serialIn(serialIn), .chainEnN(chainEnN), .updateN(updateN),
  .modeSelect(modeSelect), .serialOut(serialOut), .addrMatchN(addrMatchN), .outEnable(outEnable),
  .outGain(outGain), .outSelect(outSelect));
`default_nettype wire

// *** sim/crosspoint_serial_control_test.sv ***
// self-checking bench for the crosspoint serial control block
`timescale 1ns/10ps
`default_nettype none
module crosspoint_serial_control_test
  import crosspoint_pkg::*;
;
  localparam logic [95:0] WORD_A = 96'hFEDC_BA98_7654_3210_0F1E_2D3C;
  localparam logic [95:0] WORD_B = 96'h1234_5678_9ABC_DEF0_A5C3_3C5A;
  logic ref_clk, nrst, wbWe, wbCyc, wbStb, wbAck;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR, rd;
  logic sclk, sin, ceN, updN, mode, sout, matchN;
  logic [3:0] strap;
  logic [15:0] oEn, oGain, w16;
  logic [63:0] oSel;
  logic [95:0] expState;
  int err_count, comparisons;

  crosspoint_serial_control dut (.ref_clk(ref_clk), .nrst(nrst), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW),
    .wb_sel_i(wbSel), .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
    .shiftClock(sclk), .serialIn(sin), .chainEnN(ceN), .updateN(updN), .modeSelect(mode),
    .chipStrapAddress(strap), .serialOut(sout), .addrMatchN(matchN), .outEnable(oEn), .outGain(oGain),
    .outSelect(oSel));
  serial_host_model host (.ref_clk(ref_clk), .shiftClock(sclk), .serialIn(sin), .chainEnN(ceN),
    .updateN(updN), .modeSelect(mode), .serialOut(sout), .addrMatchN(matchN));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(logic [95:0] got, logic [95:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d, err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one classic cycle, held until ack; only the hang guard ends a wait
  task automatic wb(logic [7:0] a, logic w, logic [3:0] s, logic [31:0] d, output logic [31:0] q);
    wbAdr <= a;
    wbWe <= w;
    wbSel <= s;
    wbDatW <= d;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    @(posedge ref_clk);
    while (wbAck !== 1'b1) begin
      @(posedge ref_clk);
    end
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge ref_clk);
  endtask
  // expected latches {enables, gains, selects} from a whole-matrix word
  function automatic logic [95:0] pack(logic [95:0] w);
    logic [95:0] p;
    for (int i = 0; i < 16; i++) begin
      p[80+i] = w[6*i+5];
      p[64+i] = w[6*i+4];
      p[4*i+:4] = w[6*i+:4];
    end
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    // reset falls just after time zero so the asynchronous branches see an edge
    nrst = 1'b1;
    {wbWe, wbCyc, wbStb, wbAdr, wbDatW, wbSel} = '0;
    strap = 4'h5;
    err_count = 0;
    comparisons = 0;
    #1;
    nrst = 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    host.shiftWord(1'b1, WORD_A, 96);
    host.update(1'b0);
    expState = pack(WORD_A);
    check({oEn, oGain, oSel}, expState);
    check(host.matchSeen, 1'b1);
    // reset mid-run blanks enables only; one strobe brings them back
    nrst <= 1'b0;
    #10;
    check({oEn, oGain, oSel}, {16'h0000, expState[79:0]});
    @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    host.update(1'b0);
    check({oEn, oGain, oSel}, expState);
    host.shiftWord(1'b1, WORD_B, 96);
    check(host.seenOut, WORD_A);
    host.update(1'b1);
    check({oEn, oGain, oSel}, expState);
    host.update(1'b0);
    expState = pack(WORD_B);
    check({oEn, oGain, oSel}, expState);
    // single-output words: own address, a foreign one, then the straps move to it
    for (int k = 0; k < 3; k++) begin
      w16 = (k == 0) ? 16'hD4F9 : 16'h1822;
      strap <= (k == 2) ? 4'h6 : 4'h5;
      host.shiftWord(1'b0, {80'h0, w16}, 16);
      check(host.seenOut[15:0], w16);
      host.update(1'b0);
      check(host.matchSeen, k == 1);
      if (k != 1) begin
        expState[80 + w16[9:6]] = w16[5];
        expState[64 + w16[9:6]] = w16[4];
        expState[4 * w16[9:6] +: 4] = w16[3:0];
      end
      check({oEn, oGain, oSel}, expState);
    end
    // register view over the bus
    wb(ADR_STATUS, 1'b0, 4'hF, DATA_ZERO, rd);
    check(rd, 32'h0000_0060);
    wb(ADR_SHIFT_HI, 1'b0, 4'hF, DATA_ZERO, rd);
    check(rd, WORD_B[95:64]);
    wb(ADR_SINGLE, 1'b0, 4'hF, DATA_ZERO, rd);
    check(rd, 32'h0000_1822);
    wb(8'h3C, 1'b0, 4'hF, DATA_ZERO, rd);
    check(rd, DATA_ZERO);
    // control write without its byte lane is dropped
    wb(ADR_CTRL, 1'b1, 4'h0, 32'h0000_0001, rd);
    wb(ADR_CTRL, 1'b0, 4'hF, DATA_ZERO, rd);
    check(rd, DATA_ZERO);
    check(oEn, expState[95:80]);
    wb(ADR_CTRL, 1'b1, 4'h1, 32'h0000_0001, rd);
    wb(ADR_CTRL, 1'b0, 4'hF, DATA_ZERO, rd);
    check(rd, 32'h0000_0001);
    wb(ADR_CTRL, 1'b1, 4'h1, DATA_ZERO, rd);
    check(oEn, 16'h0000);
    wb(8'h4C, 1'b0, 4'hF, DATA_ZERO, rd);
    check(rd, 32'h0000_0019);
    finish_test();
  end

  // hang guard, well above the longest sequence
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_count++;
    finish_test();
  end
endmodule // crosspoint_serial_control_test
`default_nettype wire

// *** sim/serial_host_model.sv ***
// host model driving the serial pins of the crosspoint control block
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
  // bench clock
  input wire logic ref_clk,
  // pins toward the block
  output logic shiftClock,
  output logic serialIn,
  output logic chainEnN,
  output logic updateN,
  output logic modeSelect,
  // pins read back
  input wire logic serialOut,
  input wire logic addrMatchN
);
  logic [95:0] seenOut;
  logic matchSeen;
  // idle: link clock still and low, chain disabled
  initial begin
    shiftClock = 1'b0;
    serialIn = 1'b0;
    chainEnN = 1'b1;
    updateN = 1'b1;
    modeSelect = 1'b1;
  end
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one frame, 800 ns link period; out pin sampled before each fall
  task automatic shiftWord(logic m, logic [95:0] w, int n);
    modeSelect <= m;
    chainEnN <= 1'b0;
    tick(4);
    for (int i = n - 1; i >= 0; i--) begin
      serialIn <= w[i];
      shiftClock <= 1'b1;
      tick(4);
      seenOut[i] = serialOut;
      shiftClock <= 1'b0;
      tick(4);
    end
    // flip the released line so a stale bit never looks held
    serialIn <= ~w[0];
  endtask
  // strobe with the chain enabled or not; match pin sampled while low
  task automatic update(logic ceN);
    chainEnN <= ceN;
    tick(4);
    updateN <= 1'b0;
    tick(6);
    matchSeen = addrMatchN;
    updateN <= 1'b1;
    tick(6);
    chainEnN <= 1'b1;
    tick(2);
  endtask
endmodule // serial_host_model
`default_nettype wire
